// ### rtl/kmrm_monitor.sv
// Keypad memory and register monitor of the emulator, top level.
// Assumes a target memory port that answers each request with one ack
// pulse, and a halted slave processor that may load register fields.
`timescale 1ns/1ps
module kmrm_monitor (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic key_strobe_pin, // Keypad press level.
  input wire logic [4:0] key_code_pin, // Keypad code.
  output kmrm_pkg::kmrm_mem_req_t mem_out, // Target memory request.
  input wire logic mem_ack, // Target memory answer pulse.
  input wire logic [7:0] mem_rdata, // Target read data with ack.
  input wire logic upd_valid, // Slave processor field load pulse.
  input wire logic [4:0] upd_index, // Field to load.
  input wire logic [15:0] upd_data, // Field value.
  output logic run_start, // Execution start pulse.
  output logic [1:0] run_mode, // Full, display or step.
  output logic [15:0] run_addr, // Start address.
  output kmrm_pkg::kmrm_disp_t disp // Display contents.
);

  // ==========================================================
  // Field layout functions

  // First field of each register page.
  function automatic logic [4:0] page_first(input logic [3:0] page);
    case (page)
      4'h0: page_first = kmrm_pkg::FLD_NEXT_PC;
      4'h1: page_first = kmrm_pkg::FLD_SP;
      4'h2: page_first = kmrm_pkg::FLD_ACC;
      4'h3: page_first = kmrm_pkg::FLD_PAIR_DE;
      4'h4: page_first = kmrm_pkg::FLD_INDEX_X;
      4'h5: page_first = kmrm_pkg::FLD_ALT_FLAGS;
      4'h6: page_first = kmrm_pkg::FLD_ALT_ACC;
      4'h7: page_first = kmrm_pkg::FLD_ALT_DE;
      4'h8: page_first = kmrm_pkg::FLD_IVEC;
      default: page_first = kmrm_pkg::FLD_INTERRUPT_FLIPFLOP_TWO;
    endcase
  endfunction

  // Number of fields shown on a page, minus one.
  function automatic logic [1:0] page_last_pos(input logic [3:0] page);
    case (page)
      4'h0, 4'h2, 4'h6, 4'h8: page_last_pos = 2'h2;
      4'h5: page_last_pos = 2'h0;
      default: page_last_pos = 2'h1;
    endcase
  endfunction

  // Width mask of a field.
  function automatic logic [15:0] field_mask(input logic [4:0] idx);
    case (idx)
      kmrm_pkg::FLD_NEXT_PC, kmrm_pkg::FLD_LAST_PC, kmrm_pkg::FLD_SP,
      kmrm_pkg::FLD_PAIR_DE, 5'h09, kmrm_pkg::FLD_INDEX_X, 5'h0b,
      kmrm_pkg::FLD_ALT_DE, 5'h11: field_mask = 16'hffff;
      kmrm_pkg::FLD_IMODE: field_mask = 16'h0003;
      kmrm_pkg::FLD_INTERRUPT_FLIPFLOP_TWO, kmrm_pkg::FLD_INTERRUPT_FLIPFLOP_ONE: field_mask = 16'h0001;
      default: field_mask = 16'h00ff;
    endcase
  endfunction

  // ==========================================================
  // Key input and digit entry
  logic key_valid;
  logic [4:0] key_code;
  logic is_digit;
  logic [15:0] entry;
  logic has_digits;
  logic entry_clear;

  kmrm_key_sync u_key_sync (
    .clk(clk),
    .rst_b(rst_b),
    .key_strobe_pin(key_strobe_pin),
    .key_code_pin(key_code_pin),
    .key_valid(key_valid),
    .key_code(key_code)
  );

  assign is_digit = key_valid && key_code[4] == 1'b0;

  kmrm_hex_entry u_hex_entry (
    .clk(clk),
    .rst_b(rst_b),
    .clear(entry_clear),
    .digit_valid(is_digit),
    .digit(key_code[3:0]),
    .value(entry),
    .has_digits(has_digits)
  );

  // ==========================================================
  // Decoded keys
  kmrm_pkg::kmrm_state_t state_ff, nxt_state;
  logic busy;
  logic k_mem, k_reg, k_enter, k_adv, k_bin, k_run;

  assign busy = state_ff == kmrm_pkg::KMRM_READ || state_ff == kmrm_pkg::KMRM_WRITE ||
                state_ff == kmrm_pkg::KMRM_VERIFY;
  assign k_mem = key_valid && !busy && key_code == kmrm_pkg::KEY_MEMORY;
  assign k_reg = key_valid && !busy && key_code == kmrm_pkg::KEY_REGISTER;
  assign k_enter = key_valid && !busy && key_code == kmrm_pkg::KEY_ENTER;
  assign k_adv = key_valid && !busy && key_code == kmrm_pkg::KEY_ADVANCE;
  assign k_bin = key_valid && !busy && key_code == kmrm_pkg::KEY_BINARY;
  assign k_run = key_valid && !busy && (key_code == kmrm_pkg::KEY_RUN ||
                 key_code == kmrm_pkg::KEY_RUN_DISP || key_code == kmrm_pkg::KEY_STEP);

  // Any command key outside a memory access starts a fresh entry.
  assign entry_clear = key_valid && key_code[4] && !busy;

  // ==========================================================
  // Monitor state machine
  logic in_mem_view;
  logic verify_ok;

  assign in_mem_view = state_ff == kmrm_pkg::KMRM_SHOW || state_ff == kmrm_pkg::KMRM_ERROR;

  // Read-back holds the byte just written.
  assign verify_ok = mem_rdata == mem_out.wdata;

  // Next state from keys and memory answers.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      kmrm_pkg::KMRM_PROMPT: begin
        if (k_enter) begin
          nxt_state = kmrm_pkg::KMRM_READ;
        end
      end
      kmrm_pkg::KMRM_READ: begin
        if (mem_ack) begin
          nxt_state = kmrm_pkg::KMRM_SHOW;
        end
      end
      kmrm_pkg::KMRM_SHOW, kmrm_pkg::KMRM_ERROR: begin
        if (k_enter && has_digits) begin
          nxt_state = kmrm_pkg::KMRM_WRITE;
        end else if (k_enter || k_adv) begin
          nxt_state = kmrm_pkg::KMRM_READ;
        end
      end
      kmrm_pkg::KMRM_WRITE: begin
        if (mem_ack) begin
          nxt_state = kmrm_pkg::KMRM_VERIFY;
        end
      end
      kmrm_pkg::KMRM_VERIFY: begin
        if (mem_ack) begin
          nxt_state = verify_ok ? kmrm_pkg::KMRM_READ : kmrm_pkg::KMRM_ERROR;
        end
      end
      kmrm_pkg::KMRM_IDLE, kmrm_pkg::KMRM_REGS: begin
        nxt_state = state_ff;
      end
      default: nxt_state = kmrm_pkg::KMRM_IDLE;
    endcase
    if (k_mem) begin
      nxt_state = kmrm_pkg::KMRM_PROMPT;
    end else if (k_reg) begin
      nxt_state = kmrm_pkg::KMRM_REGS;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= kmrm_pkg::KMRM_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Memory address, data and request
  logic [15:0] addr_ff;
  logic [7:0] data_ff;
  logic err_ff;

  // Address follows entry, plain advance, and a verified write.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ff <= 16'h0000;
    end else if (state_ff == kmrm_pkg::KMRM_PROMPT && k_enter) begin
      addr_ff <= entry;
    end else if (in_mem_view && (k_adv || (k_enter && !has_digits))) begin
      addr_ff <= addr_ff + 16'h0001;
    end else if (state_ff == kmrm_pkg::KMRM_VERIFY && mem_ack && verify_ok) begin
      addr_ff <= addr_ff + 16'h0001;
    end
  end

  // Shown byte is the read data, or the bad read-back after a failure.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_ff <= 8'h00;
    end else if (mem_ack && (state_ff == kmrm_pkg::KMRM_READ ||
                             state_ff == kmrm_pkg::KMRM_VERIFY)) begin
      data_ff <= mem_rdata;
    end
  end

  // Verify error stands until the next memory, register, enter or advance key.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_ff <= 1'b0;
    end else if (state_ff == kmrm_pkg::KMRM_VERIFY && mem_ack && !verify_ok) begin
      err_ff <= 1'b1;
    end else if (k_mem || k_reg || k_enter || k_adv) begin
      err_ff <= 1'b0;
    end
  end

  // Request stands from entry into an access state until its ack.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_out <= '0;
    end else begin
      mem_out.req <= nxt_state == kmrm_pkg::KMRM_READ || nxt_state == kmrm_pkg::KMRM_WRITE ||
                     nxt_state == kmrm_pkg::KMRM_VERIFY;
      mem_out.we <= nxt_state == kmrm_pkg::KMRM_WRITE;
      if (state_ff == kmrm_pkg::KMRM_PROMPT && k_enter) begin
        mem_out.addr <= entry;
      end else if (nxt_state == kmrm_pkg::KMRM_READ && state_ff != kmrm_pkg::KMRM_READ) begin
        mem_out.addr <= addr_ff + 16'h0001;
      end else if (nxt_state == kmrm_pkg::KMRM_WRITE) begin
        mem_out.addr <= addr_ff;
      end
      if (in_mem_view && k_enter && has_digits) begin
        mem_out.wdata <= entry[7:0];
      end
    end
  end

  // ==========================================================
  // Processor register file
  logic [15:0] fld_ff [0:kmrm_pkg::NUM_FIELDS-1];
  logic [3:0] page_ff;
  logic [1:0] pos_ff;
  logic bin_ff;
  logic [4:0] cur_fld;
  logic reg_write;

  assign cur_fld = page_first(page_ff) + {3'h0, pos_ff};
  assign reg_write = state_ff == kmrm_pkg::KMRM_REGS && k_enter && has_digits;

  // Keypad writes win over a slave load in the same cycle.
  generate
    for (genvar i = 0; i < kmrm_pkg::NUM_FIELDS; i++) begin : g_fld
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          fld_ff[i] <= kmrm_pkg::FIELD_RESET;
        end else if (reg_write && cur_fld == 5'(i)) begin
          fld_ff[i] <= entry & field_mask(5'(i));
        end else if (upd_valid && upd_index == 5'(i)) begin
          fld_ff[i] <= upd_data & field_mask(5'(i));
        end
      end
    end
  endgenerate

  // Page walk, field cursor and binary view.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_ff <= kmrm_pkg::PAGE_PC;
      pos_ff <= 2'h0;
      bin_ff <= 1'b0;
    end else if (k_reg) begin
      page_ff <= kmrm_pkg::PAGE_PC;
      pos_ff <= 2'h0;
      bin_ff <= 1'b0;
    end else if (state_ff == kmrm_pkg::KMRM_REGS) begin
      if (k_adv) begin
        page_ff <= (page_ff == kmrm_pkg::PAGE_LAST) ? kmrm_pkg::PAGE_PC
                                                   : page_ff + 4'h1;
        pos_ff <= 2'h0;
        bin_ff <= 1'b0;
      end else if (k_bin && page_ff == kmrm_pkg::PAGE_SP_FLAGS) begin
        bin_ff <= 1'b1;
      end else if (k_enter) begin
        pos_ff <= (pos_ff == page_last_pos(page_ff)) ? 2'h0 : pos_ff + 2'h1;
      end
    end
  end

  // ==========================================================
  // Execution start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_start <= 1'b0;
      run_mode <= kmrm_pkg::RUN_FULL;
      run_addr <= 16'h0000;
    end else begin
      run_start <= k_run;
      if (k_run) begin
        run_addr <= fld_ff[kmrm_pkg::FLD_NEXT_PC];
        case (key_code)
          kmrm_pkg::KEY_RUN_DISP: run_mode <= kmrm_pkg::RUN_DISPLAY;
          kmrm_pkg::KEY_STEP: run_mode <= kmrm_pkg::RUN_STEP;
          default: run_mode <= kmrm_pkg::RUN_FULL;
        endcase
      end
    end
  end

  // ==========================================================
  // Display register
  logic [4:0] f0, f1, f2;

  assign f0 = page_first(page_ff);
  assign f1 = (page_last_pos(page_ff) >= 2'h1) ? f0 + 5'h01 : f0;
  assign f2 = (page_last_pos(page_ff) == 2'h2) ? f0 + 5'h02 : f0;

  // Fields of the current page, one line; binary always on the alternate flag page, on the SP and flags page only after the binary key.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      disp <= '0;
    end else begin
      disp.mode <= state_ff;
      disp.page <= page_ff;
      disp.addr <= addr_ff;
      disp.data <= data_ff;
      disp.field0 <= fld_ff[f0];
      disp.field1 <= (f1 == f0) ? 16'h0000 : fld_ff[f1];
      disp.field2 <= (f2 == f0) ? 16'h0000 : fld_ff[f2];
      disp.cursor <= pos_ff;
      disp.binary <= bin_ff || page_ff == kmrm_pkg::PAGE_ALT_FLAGS;
      disp.entry <= entry;
      disp.verify_err <= err_ff;
    end
  end

endmodule // kmrm_monitor

// ### rtl/kmrm_pkg.sv
// Constants, key codes, register field map and carrier types of the keypad monitor.
// Assumes one 100 MHz clock and a target memory port answered on the same clock.
package kmrm_pkg;

  // ==========================================================
  // Key codes
  localparam logic [4:0] KEY_MEMORY = 5'h10;
  localparam logic [4:0] KEY_REGISTER = 5'h11;
  localparam logic [4:0] KEY_ENTER = 5'h12;
  localparam logic [4:0] KEY_ADVANCE = 5'h13;
  localparam logic [4:0] KEY_BINARY = 5'h14;
  localparam logic [4:0] KEY_RUN = 5'h15;
  localparam logic [4:0] KEY_RUN_DISP = 5'h16;
  localparam logic [4:0] KEY_STEP = 5'h17;

  // ==========================================================
  // Processor register fields, in page order
  localparam logic [4:0] FLD_NEXT_PC = 5'h00;
  localparam logic [4:0] FLD_LAST_PC = 5'h01;
  localparam logic [4:0] FLD_INSN = 5'h02;
  localparam logic [4:0] FLD_SP = 5'h03;
  localparam logic [4:0] FLD_FLAGS = 5'h04;
  localparam logic [4:0] FLD_ACC = 5'h05;
  localparam logic [4:0] FLD_PAIR_DE = 5'h08;
  localparam logic [4:0] FLD_INDEX_X = 5'h0a;
  localparam logic [4:0] FLD_ALT_FLAGS = 5'h0c;
  localparam logic [4:0] FLD_ALT_ACC = 5'h0d;
  localparam logic [4:0] FLD_ALT_DE = 5'h10;
  localparam logic [4:0] FLD_IVEC = 5'h12;
  localparam logic [4:0] FLD_REFRESH = 5'h13;
  localparam logic [4:0] FLD_IMODE = 5'h14;
  localparam logic [4:0] FLD_INTERRUPT_FLIPFLOP_TWO = 5'h15;
  localparam logic [4:0] FLD_INTERRUPT_FLIPFLOP_ONE = 5'h16;
  localparam int NUM_FIELDS = 23;

  // ==========================================================
  // Register pages
  localparam logic [3:0] PAGE_PC = 4'h0;
  localparam logic [3:0] PAGE_SP_FLAGS = 4'h1;
  localparam logic [3:0] PAGE_ALT_FLAGS = 4'h5;
  localparam logic [3:0] PAGE_LAST = 4'h9;

  // ==========================================================
  // Run modes and reset values
  localparam logic [1:0] RUN_FULL = 2'h0;
  localparam logic [1:0] RUN_DISPLAY = 2'h1;
  localparam logic [1:0] RUN_STEP = 2'h2;
  localparam logic [15:0] FIELD_RESET = 16'h0000;

  // ==========================================================
  // Monitor states, Gray coded along the memory path
  typedef enum logic [2:0] {
    KMRM_IDLE = 3'h0,
    KMRM_PROMPT = 3'h1,
    KMRM_READ = 3'h3,
    KMRM_SHOW = 3'h2,
    KMRM_WRITE = 3'h6,
    KMRM_VERIFY = 3'h7,
    KMRM_ERROR = 3'h5,
    KMRM_REGS = 3'h4
  } kmrm_state_t;

  // Target memory request.
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } kmrm_mem_req_t;

  // Display contents.
  typedef struct packed {
    kmrm_state_t mode;
    logic [3:0] page;
    logic [15:0] addr;
    logic [7:0] data;
    logic [15:0] field0;
    logic [15:0] field1;
    logic [15:0] field2;
    logic [1:0] cursor;
    logic binary;
    logic [15:0] entry;
    logic verify_err;
  } kmrm_disp_t;

endpackage

// ### rtl/kmrm_key_sync.sv
// Keypad input synchroniser: strobe and code pins pass three flip-flops.
// Assumes the keypad holds the code steady while the strobe is high.
`timescale 1ns/1ps
module kmrm_key_sync (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic key_strobe_pin, // Key pressed level from the keypad.
  input wire logic [4:0] key_code_pin, // Key code from the keypad.
  output logic key_valid, // One-cycle pulse per key press.
  output logic [4:0] key_code // Code of the accepted key.
);

  logic [2:0] strobe_ff;
  logic [4:0] code1_ff, code2_ff, code3_ff;
  logic pressed_ff;
  logic [4:0] key_code_ff;

  // Three-stage chains; only stages two and three are compared.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_ff <= 3'h0;
      code1_ff <= 5'h00;
      code2_ff <= 5'h00;
      code3_ff <= 5'h00;
    end else begin
      strobe_ff <= {strobe_ff[1:0], key_strobe_pin};
      code1_ff <= key_code_pin;
      code2_ff <= code1_ff;
      code3_ff <= code2_ff;
    end
  end

  // A press counts once stages two and three agree on a high strobe.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pressed_ff <= 1'b0;
      key_code_ff <= 5'h00;
      key_valid <= 1'b0;
    end else begin
      key_valid <= 1'b0;
      if (strobe_ff[1] == strobe_ff[2]) begin
        pressed_ff <= strobe_ff[2];
        if (strobe_ff[2] && !pressed_ff && code2_ff == code3_ff) begin
          key_valid <= 1'b1;
          key_code_ff <= code3_ff;
        end
      end
    end
  end

  assign key_code = key_code_ff;

endmodule // kmrm_key_sync

// ### rtl/kmrm_hex_entry.sv
// Hex digit accumulator for addresses and data typed on the keypad.
// Assumes one digit pulse per key and a clear pulse from the monitor.
`timescale 1ns/1ps
module kmrm_hex_entry (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic clear, // Drops the typed value.
  input wire logic digit_valid, // One digit key this cycle.
  input wire logic [3:0] digit, // Digit value.
  output logic [15:0] value, // Last four digits typed.
  output logic has_digits // At least one digit since clear.
);

  logic [15:0] value_ff;
  logic has_ff;

  // Shift each new digit in from the right; clear has priority.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      value_ff <= 16'h0000;
      has_ff <= 1'b0;
    end else if (clear) begin
      value_ff <= 16'h0000;
      has_ff <= 1'b0;
    end else if (digit_valid) begin
      value_ff <= {value_ff[11:0], digit};
      has_ff <= 1'b1;
    end
  end

  assign value = value_ff;
  assign has_digits = has_ff;

endmodule // kmrm_hex_entry

// ### verif/kmrm_asserts.sv
// Concurrent checks on the keypad monitor top-level ports.
// Assumes a bind onto kmrm_monitor and a target that answers one request at a time.
`timescale 1ns/1ps
module kmrm_asserts (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic key_strobe_pin, // Keypad press level.
  input wire logic [4:0] key_code_pin, // Keypad code.
  input kmrm_pkg::kmrm_mem_req_t mem_out, // Target memory request.
  input wire logic mem_ack, // Target answer pulse.
  input wire logic [7:0] mem_rdata, // Target read data.
  input wire logic run_start, // Execution start pulse.
  input wire logic [1:0] run_mode, // Run mode.
  input kmrm_pkg::kmrm_disp_t disp // Display contents.
);
  logic vp_ff;
  logic stb_ff;
  logic [15:0] wa_ff;
  logic [7:0] wd_ff;
  logic [7:0] rd_ff;
  logic [4:0] key_ff;

  // ==========
  // Helper logic
  // Notes the last write, a pending read-back, the read data at the last ack and the last key.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vp_ff <= 1'b0;
      stb_ff <= 1'b0;
      wa_ff <= 16'h0000;
      wd_ff <= 8'h00;
      rd_ff <= 8'h00;
      key_ff <= 5'h00;
    end else begin
      stb_ff <= key_strobe_pin;
      if (key_strobe_pin && !stb_ff) key_ff <= key_code_pin;
      if (mem_ack) vp_ff <= mem_out.we;
      if (mem_ack) rd_ff <= mem_rdata;
      if (mem_ack && mem_out.we) wa_ff <= mem_out.addr;
      if (mem_ack && mem_out.we) wd_ff <= mem_out.wdata;
    end
  end

  // ==========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_ack;
    mem_ack && mem_out.we;
  endsequence
  sequence s_vfy_ok;
    mem_ack && vp_ff && mem_rdata == wd_ff;
  endsequence
  property p_req_hold;
    mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_verify;
    s_wr_ack |-> ##[1:4] (mem_out.req && !mem_out.we && mem_out.addr == wa_ff);
  endproperty
  a_verify: assert property (p_verify) else $error("no read-back after write");
  property p_step;
    s_vfy_ok |-> ##[1:4] (mem_out.req && !mem_out.we && mem_out.addr == wa_ff + 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("no read of next address");
  property p_err;
    mem_ack && vp_ff && mem_rdata != wd_ff |-> ##[1:4]
      (disp.verify_err && disp.mode == kmrm_pkg::KMRM_ERROR && disp.addr == wa_ff);
  endproperty
  a_err: assert property (p_err) else $error("bad read-back not flagged");
  property p_show;
    mem_ack && !mem_out.we && !vp_ff |-> ##[1:4]
      (disp.mode == kmrm_pkg::KMRM_SHOW && disp.data == rd_ff);
  endproperty
  a_show: assert property (p_show) else $error("read byte not shown");
  property p_prompt;
    $rose(disp.mode == kmrm_pkg::KMRM_PROMPT) |-> !mem_out.req [*3];
  endproperty
  a_prompt: assert property (p_prompt) else $error("memory access during prompt");
  property p_write_key;
    $rose(mem_out.req && mem_out.we) |-> key_ff == kmrm_pkg::KEY_ENTER;
  endproperty
  a_write_key: assert property (p_write_key) else $error("write without enter");
  property p_page;
    disp.mode == kmrm_pkg::KMRM_REGS && $past(disp.mode) == kmrm_pkg::KMRM_REGS &&
      disp.page != $past(disp.page) |-> disp.page == 4'h0 || disp.page == $past(disp.page) + 4'h1;
  endproperty
  a_page: assert property (p_page) else $error("register page out of order");
  property p_run;
    run_start |-> (key_ff - kmrm_pkg::KEY_RUN) == {3'h0, run_mode} ##1 !run_start;
  endproperty
  a_run: assert property (p_run) else $error("run pulse or mode wrong");
endmodule // kmrm_asserts

bind kmrm_monitor kmrm_asserts u_asserts (.clk(clk), .rst_b(rst_b),
  .key_strobe_pin(key_strobe_pin), .key_code_pin(key_code_pin), .mem_out(mem_out),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata), .run_start(run_start), .run_mode(run_mode),
  .disp(disp));

// ### verif/kmrm_target_mem.sv
// Behavioural target memory that answers the monitor's requests.
// Assumes one request at a time, held until its ack.
`timescale 1ns/1ps
module kmrm_target_mem (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Reset, active low.
  input kmrm_pkg::kmrm_mem_req_t mem_out, // Request from the monitor.
  input wire logic [2:0] lat, // Extra answer delay in cycles.
  input wire logic bad, // Flips bit 0 of read data.
  output logic mem_ack, // Answer pulse.
  output logic [7:0] mem_rdata // Read data.
);
  logic [7:0] mem [65536];
  logic [2:0] cnt;

  // Fills memory with a pattern of the address.
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
  end

  // Answers lat + 1 cycles after a request appears; read data toggles in every cycle without a read answer.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 3'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_out.req && !mem_ack) begin
        cnt <= cnt + 3'h1;
        if (cnt >= lat) begin
          cnt <= 3'h0;
          mem_ack <= 1'b1;
          if (mem_out.we) mem[mem_out.addr] <= mem_out.wdata;
          else mem_rdata <= mem[mem_out.addr] ^ {7'h00, bad};
        end
      end
    end
  end
endmodule // kmrm_target_mem

// ### verif/test_keypad_memory_register_monitor.sv
// Self-checking bench of the keypad monitor with a target memory model.
// Assumes the package and monitor under rtl/ and the checker bound by its own file.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module test_keypad_memory_register_monitor;
  logic clk, rst_b, key_strobe_pin, mem_ack, upd_valid, run_start, bad, req_q, ack_q;
  logic [4:0] key_code_pin, upd_index;
  logic [7:0] mem_rdata, d;
  logic [7:0] dv [3];
  logic [15:0] upd_data, run_addr, a, pc;
  logic [17:0] er;
  logic [1:0] run_mode;
  logic [2:0] lat;
  kmrm_pkg::kmrm_mem_req_t mem_out, e;
  kmrm_pkg::kmrm_disp_t disp;
  kmrm_pkg::kmrm_mem_req_t exp_mem[$];
  logic [17:0] exp_run[$];
  int failures, num_checks;

  kmrm_monitor dut (.clk(clk), .rst_b(rst_b), .key_strobe_pin(key_strobe_pin),
    .key_code_pin(key_code_pin), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .upd_valid(upd_valid), .upd_index(upd_index), .upd_data(upd_data), .run_start(run_start),
    .run_mode(run_mode), .run_addr(run_addr), .disp(disp));
  kmrm_target_mem u_mem (.clk(clk), .rst_b(rst_b), .mem_out(mem_out), .lat(lat), .bad(bad),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // Makes the 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares each new memory request and run pulse with the oldest note.
  always @(posedge clk) begin
    if (rst_b && mem_out.req === 1'b1 && (!req_q || ack_q)) begin
      `CHK(exp_mem.size() > 0, 1'b1)
      if (exp_mem.size() > 0) begin
        e = exp_mem.pop_front();
        `CHK({mem_out.we, mem_out.addr}, {e.we, e.addr})
        if (e.we) `CHK(mem_out.wdata, e.wdata)
      end
    end
    if (run_start === 1'b1) begin
      `CHK(exp_run.size() > 0, 1'b1)
      if (exp_run.size() > 0) begin
        er = exp_run.pop_front();
        `CHK({run_mode, run_addr}, er)
      end
    end
    req_q <= mem_out.req;
    ack_q <= mem_ack;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Waits until the memory port has been quiet for eight cycles.
  task automatic settle;
    int q;
    q = 0;
    for (int n = 0; n < 300 && q < 8; n++) begin
      @(negedge clk);
      q = (mem_out.req === 1'b1) ? 0 : q + 1;
    end
    if (q < 8) begin
      failures++;
      close_out();
    end
  endtask

  task automatic press(input logic [4:0] k);
    @(negedge clk);
    key_code_pin = k;
    key_strobe_pin = 1'b1;
    repeat (4) @(negedge clk);
    key_strobe_pin = 1'b0;
    repeat (4) @(negedge clk);
    settle();
  endtask

  task automatic word(input logic [15:0] v);
    for (int i = 3; i >= 0; i--) press({1'b0, v[i*4 +: 4]});
  endtask

  task automatic byt(input logic [7:0] v);
    for (int i = 1; i >= 0; i--) press({1'b0, v[i*4 +: 4]});
  endtask

  task automatic rd(input logic [15:0] ad);
    exp_mem.push_back({1'b1, 1'b0, ad, 8'h00});
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] dt);
    exp_mem.push_back({1'b1, 1'b1, ad, dt});
    rd(ad);
  endtask

  task automatic upd(input logic [4:0] ix, input logic [15:0] v);
    @(negedge clk);
    upd_valid = 1'b1;
    upd_index = ix;
    upd_data = v;
    @(negedge clk);
    upd_valid = 1'b0;
  endtask

  // Resets the monitor, then runs the memory, error, register and run tests.
  initial begin
    {key_strobe_pin, key_code_pin, upd_valid, upd_index, upd_data} = '0;
    {bad, lat, rst_b, req_q, ack_q} = '0;
    failures = 0;
    num_checks = 0;
    void'($urandom(32'hb7f3429e));
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    `CHK({disp, mem_out, run_start}, '0)
    press(kmrm_pkg::KEY_MEMORY);
    `CHK(disp.mode, kmrm_pkg::KMRM_PROMPT)
    a = {1'b0, 15'($urandom)};
    rd(a);
    word(a);
    press(kmrm_pkg::KEY_ENTER);
    `CHK({disp.addr, disp.data}, {a, a[7:0] ^ 8'h5a})
    for (int i = 0; i < 3; i++) begin
      dv[i] = 8'($urandom);
      lat = 3'($urandom_range(4));
      wr(16'(a + i), dv[i]);
      rd(16'(a + i + 1));
      byt(dv[i]);
      press(kmrm_pkg::KEY_ENTER);
      `CHK({disp.addr, disp.data}, {16'(a + i + 1), 8'(a + i + 1) ^ 8'h5a})
    end
    press(kmrm_pkg::KEY_MEMORY);
    rd(a);
    word(a);
    press(kmrm_pkg::KEY_ENTER);
    `CHK(disp.data, dv[0])
    rd(a + 16'h1);
    press(kmrm_pkg::KEY_ADVANCE);
    `CHK({disp.addr, disp.data}, {a + 16'h1, dv[1]})
    $display("memory test done");
    bad = 1'b1;
    d = ~dv[1];
    wr(a + 16'h1, d);
    byt(d);
    press(kmrm_pkg::KEY_ENTER);
    `CHK({disp.verify_err, disp.mode, disp.addr}, {1'b1, kmrm_pkg::KMRM_ERROR, a + 16'h1})
    bad = 1'b0;
    rd(a + 16'h2);
    press(kmrm_pkg::KEY_ADVANCE);
    `CHK({disp.verify_err, disp.data}, {1'b0, dv[2]})
    $display("verify error test done");
    press(kmrm_pkg::KEY_REGISTER);
    `CHK({disp.mode, disp.page}, {kmrm_pkg::KMRM_REGS, kmrm_pkg::PAGE_PC})
    pc = 16'($urandom);
    word(pc);
    `CHK(disp.entry, pc)
    press(kmrm_pkg::KEY_ENTER);
    `CHK({disp.field0, disp.cursor}, {pc, 2'h1})
    upd(kmrm_pkg::FLD_IVEC, {8'h00, d});
    upd(kmrm_pkg::FLD_REFRESH, {8'h00, ~d});
    upd(kmrm_pkg::FLD_IMODE, 16'h0002);
    for (int p = 1; p <= 10; p++) begin
      press(kmrm_pkg::KEY_ADVANCE);
      `CHK(disp.page, 4'(p % 10))
      if (p == 1) begin
        `CHK(disp.binary, 1'b0)
        press(kmrm_pkg::KEY_BINARY);
        `CHK(disp.binary, 1'b1)
      end
      if (p == 5) `CHK(disp.binary, 1'b1)
      if (p == 8) `CHK({disp.field0, disp.field1, disp.field2}, {8'h00, d, 8'h00, ~d, 16'h2})
    end
    $display("register test done");
    for (int k = 0; k < 3; k++) begin
      exp_run.push_back({2'(k), pc});
      press(5'(kmrm_pkg::KEY_RUN + k));
    end
    upd(kmrm_pkg::FLD_NEXT_PC, ~pc);
    exp_run.push_back({kmrm_pkg::RUN_STEP, ~pc});
    press(kmrm_pkg::KEY_STEP);
    `CHK(exp_mem.size() + exp_run.size() == 0, 1'b1)
    $display("run test done");
    close_out();
  end
endmodule // test_keypad_memory_register_monitor
